// ==== rx_modem_rssi_monitor_test.sv ====
// Self-checking bench for the receive signal-quality monitor.
// Assumes the host model drives APB and the bench the modem side.
`timescale 1ns/1ps
module rx_modem_rssi_monitor_test;
    import rxsq_pkg::*;
    logic clk, rst_n, rx, bstb, pre, syn, pbusy;
    logic [7:0] str, raw;
    logic [6:0] off;
    logic [31:0] paddr, pwdata, prdata, seed;
    logic psel, pen, pwr, pready, perr, jev, rrst, thl, thn, crun;
    int fails, n_tests, njump, nrst, ncal, cyc, nj, nr, nc, d;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    rxsq_monitor #(.CAL_FIRST_CYC(50), .CAL_RE_CYC(20)) dut (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_PADDR(paddr), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
        .I_RX_ACTIVE(rx), .I_BIT_STB(bstb), .I_STRENGTH(str),
        .I_PREAMBLE_DET(pre), .I_SYNC_DET(syn), .I_PACKET_BUSY(pbusy),
        .O_JUMP_EVT(jev), .O_RX_RESTART(rrst), .O_THRESH_LATCHED(thl),
        .O_THRESH_LEVEL(thn), .O_CAL_RUN(crun));

    rxsq_host_model host (
        .i_clk(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(perr), .o_paddr(paddr), .o_psel(psel),
        .o_penable(pen), .o_pwrite(pwr), .o_pwdata(pwdata));

    // Tally pulses and calibration cycles mid-cycle, where they are settled,
    // so a count is up to date when the bench reads it at the next edge
    always @(negedge clk) begin
        if (jev === 1'b1) njump <= njump + 1;
        if (rrst === 1'b1) nrst <= nrst + 1;
        if (crun === 1'b1) ncal <= ncal + 1;
    end

    function automatic logic [31:0] rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : rnd

    // Compensated strength, clamped to the 8-bit code range
    function automatic logic [31:0] exp_str(input logic [7:0] r,
                                            input logic [6:0] o);
        int v;
        v = int'(r) + 2 * int'(o) - 100;
        return (v < 0) ? 32'h0000_0000 : (v > 255) ? 32'h0000_00FF : v;
    endfunction : exp_str

    task chk(input string nm, input logic [31:0] ex,
             input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] dt);
        host.xfer(1'b1, a, dt);
    endtask : wr

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        host.xfer(1'b0, a, 32'h0000_0000);
        chk(nm, ex, host.q);
    endtask : rdchk

    // Bit periods four cycles apart, strength held after the strobe
    task bits(input int n, input logic [7:0] v);
        repeat (n) begin
            @(posedge clk);
            bstb <= 1'b1;
            str <= v;
            @(posedge clk);
            bstb <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : bits

    task rx_go();
        @(posedge clk);
        rx <= 1'b0;
        @(posedge clk);
        rx <= 1'b1;
        @(posedge clk);
    endtask : rx_go

    task det(input logic s);
        @(posedge clk);
        pre <= ~s;
        syn <= s;
        @(posedge clk);
        pre <= 1'b0;
        syn <= 1'b0;
    endtask : det

    task complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Run needs some 24k cycles; a stuck poll ends here
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        {rx, bstb, pre, syn, pbusy} = '0;
        str = 8'h00;
        seed = 32'h3281_1110;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        rdchk("config", RXSQ_CONFIG_OFF, RXSQ_CONFIG_RST);
        rdchk("jump cfg", RXSQ_JUMP_OFF, RXSQ_JUMP_RST);
        rdchk("offset", RXSQ_OFFSET_OFF, 32'(RXSQ_OFFSET_RST));
        rdchk("thresh", RXSQ_THRESH_OFF, 32'(RXSQ_THRESH_RST));
        rdchk("unmapped", 8'h40, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, 32'(host.e));
        // Count trigger: zero before the floor, then held all packet
        rx_go();
        bits(3, 8'h55);
        rdchk("fast early", RXSQ_FAST_OFF, 32'h0000_0000);
        bits(2, 8'h55);
        for (int s = 0; s < 4; s++) begin
            wr(RXSQ_FAST_SEL_OFF, 32'(s));
            rdchk("lane", RXSQ_FAST_OFF, 32'h0000_0055 << (8 * s));
        end
        bits(3, 8'h22);
        rdchk("fast held", RXSQ_FAST_OFF, 32'h5500_0000);
        rx_go();
        rdchk("fast clear", RXSQ_FAST_OFF, 32'h0000_0000);
        wr(RXSQ_FAST_SEL_OFF, 32'h0000_0000);
        // Averaging, preamble trigger held off until seven bits
        wr(RXSQ_CONFIG_OFF, 32'h0000_0404);
        rx_go();
        for (int i = 1; i < 5; i++) bits(1, 8'(i * 16));
        host.query(cyc);
        chk("avg", 32'h0000_0028, host.q & 32'h0000_00FF);
        det(1'b0);
        rdchk("pre early", RXSQ_FAST_OFF, 32'h0000_0000);
        bits(4, 8'h28);
        det(1'b0);
        rdchk("pre latch", RXSQ_FAST_OFF, 32'h0000_0028);
        // Sync source ignores a preamble pulse
        wr(RXSQ_CONFIG_OFF, 32'h0000_0405);
        rx_go();
        bits(8, 8'h28);
        det(1'b0);
        rdchk("sync wait", RXSQ_FAST_OFF, 32'h0000_0000);
        det(1'b1);
        rdchk("sync latch", RXSQ_FAST_OFF, 32'h0000_0028);
        // Offset and live strength through the query, corners first
        wr(RXSQ_CONFIG_OFF, RXSQ_CONFIG_RST);
        for (int i = 0; i < 6; i++) begin
            seed = rnd(seed);
            raw = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
            off = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : seed[14:8];
            wr(RXSQ_OFFSET_OFF, 32'(off));
            bits(1, raw);
            host.query(cyc);
            chk("qtime", 1, 32'(cyc > 3280 && cyc < 3320));
            chk("current", exp_str(raw, off), host.q & 32'h00FF);
            chk("latched", 32'h0028, (host.q >> 8) & 32'h00FF);
        end
        wr(RXSQ_OFFSET_OFF, 32'(RXSQ_OFFSET_RST));
        // Level is strictly above; the latched copy sticks until cleared
        // Strength set first so a leftover random code cannot trip the latch
        bits(1, 8'h80);
        wr(RXSQ_THRESH_OFF, 32'h0000_0080);
        chk("thr eq", 32'h0000_0000, {30'h0000_0000, thl, thn});
        bits(1, 8'h81);
        chk("thr above", 32'h0000_0003, {30'h0000_0000, thl, thn});
        bits(1, 8'h10);
        chk("thr stick", 32'h0000_0002, {30'h0000_0000, thl, thn});
        wr(RXSQ_CTRL_OFF, 32'h0000_0002);
        @(posedge clk);
        chk("thr clear", 32'h0000_0000, {30'h0000_0000, thl, thn});
        // Jumps count only when enabled and inside a packet
        pbusy <= 1'b1;
        nj = njump;
        nr = nrst;
        bits(1, 8'h10);
        bits(1, 8'hF0);
        chk("jump off", nj, njump);
        wr(RXSQ_JUMP_OFF, 32'h0000_2003);
        bits(1, 8'hF0);
        bits(1, 8'h10);
        chk("jump evt", nj + 1, njump);
        chk("restart", nr + 1, nrst);
        bits(1, 8'h20);
        pbusy <= 1'b0;
        bits(1, 8'hF0);
        chk("no jump", nj + 1, njump);
        wr(RXSQ_JUMP_OFF, 32'h0000_2001);
        pbusy <= 1'b1;
        bits(1, 8'hF0);
        bits(1, 8'h10);
        chk("jump only", nj + 2, njump);
        chk("no restart", nr + 1, nrst);
        // First calibration runs long, later ones short
        for (int i = 0; i < 2; i++) begin
            nc = ncal;
            host.recal();
            repeat (80) @(posedge clk);
            d = ncal - nc - (i == 0 ? 50 : 20);
            chk("cal span", 1, 32'(d >= -1 && d <= 1));
        end
        // Status: cal done, query ready, threshold and jump sticky bits set
        rdchk("status", RXSQ_STATUS_OFF, 32'h0000_0036);
        wr(RXSQ_CTRL_OFF, 32'h0000_0002);
        rdchk("status clr", RXSQ_STATUS_OFF, 32'h0000_0030);
        // Averaged count trigger waits for seven bits despite a count of four
        wr(RXSQ_CONFIG_OFF, 32'h0000_0406);
        rx_go();
        bits(6, 8'h30);
        rdchk("avg cnt early", RXSQ_FAST_OFF, 32'h0000_0000);
        bits(2, 8'h30);
        rdchk("avg cnt latch", RXSQ_FAST_OFF, 32'h0000_0030);
        complete_run();
    end
endmodule : rx_modem_rssi_monitor_test

// ==== rxsq_host_model.sv ====
// Host model: APB master standing in for the host controller.
// Assumes its tasks are called from a single bench process.
`timescale 1ns/1ps
module rxsq_host_model (
    input wire logic i_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output logic [31:0] o_paddr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [31:0] o_pwdata
);
    import rxsq_pkg::*;
    logic [31:0] q;
    logic e;
    initial begin
        {o_paddr, o_psel, o_penable, o_pwrite, o_pwdata} = '0;
    end
    // One transfer; idle edge first so calls never collide
    // Any register, fast word too, is read after an i_pready poll
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_paddr <= {24'h00_0000, a};
        o_pwrite <= w;
        o_pwdata <= d;
        o_psel <= 1'b1;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
    // Query, then poll ready before fetching; bench bounds the wait
    task query(output int cyc);
        xfer(1'b1, RXSQ_QUERY_OFF, 32'h0000_0000);
        cyc = 0;
        do begin
            xfer(1'b0, RXSQ_STATUS_OFF, 32'h0000_0000);
            cyc += 3;
        end while (q[RXSQ_ST_CTS_BIT] !== 1'b1);
        xfer(1'b0, RXSQ_QUERY_OFF, 32'h0000_0000);
    endtask : query
    // Calibration start; repeating it after drift is the caller's job
    task recal();
        xfer(1'b1, RXSQ_CTRL_OFF, 32'h0000_0001);
    endtask : recal
endmodule : rxsq_host_model

// ==== rxsq_monitor.sv ====
// Receive signal strength monitor with latching, averaging, offset,
// jump and threshold detection, fast status word, query and image cal.
// Assumes strength samples and the bit strobe come from the same clock.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module rxsq_monitor #(
    parameter int CAL_FIRST_CYC = rxsq_pkg::RXSQ_CAL_FIRST_CYC,
    parameter int CAL_RE_CYC = rxsq_pkg::RXSQ_CAL_RE_CYC
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic [31:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_RX_ACTIVE,
    input wire logic I_BIT_STB,
    input wire logic [7:0] I_STRENGTH,
    input wire logic I_PREAMBLE_DET,
    input wire logic I_SYNC_DET,
    input wire logic I_PACKET_BUSY,
    output logic O_JUMP_EVT,
    output logic O_RX_RESTART,
    output logic O_THRESH_LATCHED,
    output logic O_THRESH_LEVEL,
    output logic O_CAL_RUN
);
    import rxsq_pkg::*;

    logic [31:0] config_q;
    logic [31:0] jump_q;
    logic [6:0] offset_q;
    logic [7:0] thresh_q;
    logic [1:0] fast_sel_q;
    logic rx_q;
    logic rx_start;
    logic [7:0] bits_q;
    logic [1:0] avg_n_q;
    logic [9:0] avg_acc_q;
    logic [7:0] cur_q;
    logic [7:0] latched_q;
    logic latch_done_q;
    logic [7:0] prev_q;
    logic prev_ok_q;
    logic jump_st_q;
    logic thl_q;
    logic [7:0] q_cur_q;
    logic [7:0] q_lat_q;
    logic [12:0] cts_cnt_q;
    logic cts_q;
    rxsq_cal_t cal_q;
    logic cal_done_q;
    logic first_cal_q;
    logic [27:0] cal_cnt_q;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [7:0] off_adj;
    logic [7:0] latch_min;
    logic latch_evt;
    logic jump_hit;
    logic [7:0] jump_diff;
    logic [8:0] comp_sum;
    logic [7:0] comp_val;
    logic [9:0] avg_sum;

    // APB strobes; every access completes in its first access cycle
    // Unmapped writes are refused, so an alias of a low byte never lands
    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && mapped;
    assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
    assign O_PREADY = 1'b1;
    assign mapped = (I_PADDR[31:8] == 24'h00_0000) && (I_PADDR[1:0] == 2'h0)
        && (I_PADDR[7:0] <= RXSQ_MODEM_OFF);
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    // Software-written configuration
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            config_q <= RXSQ_CONFIG_RST;
            jump_q <= RXSQ_JUMP_RST;
            offset_q <= RXSQ_OFFSET_RST;
            thresh_q <= RXSQ_THRESH_RST;
            fast_sel_q <= 2'h0;
        end else if (wr_en) begin
            unique case (I_PADDR[7:0])
                RXSQ_CONFIG_OFF: config_q <= I_PWDATA;
                RXSQ_JUMP_OFF: jump_q <= I_PWDATA;
                RXSQ_OFFSET_OFF: offset_q <= I_PWDATA[6:0];
                RXSQ_THRESH_OFF: thresh_q <= I_PWDATA[7:0];
                RXSQ_FAST_SEL_OFF: fast_sel_q <= I_PWDATA[1:0];
                default: ;
            endcase
        end
    end

    // Receive entry edge and bit counter since entry
    assign rx_start = I_RX_ACTIVE && !rx_q;
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            rx_q <= 1'b0;
            bits_q <= 8'h00;
        end else begin
            rx_q <= I_RX_ACTIVE;
            if (rx_start) begin
                bits_q <= 8'h00;
            end else if (I_BIT_STB && bits_q != 8'hFF) begin
                bits_q <= bits_q + 8'h01;
            end
        end
    end

    // Offset in 1 dB steps is two half-dB codes per step; clamp at ends
    assign off_adj = {offset_q, 1'b0};
    assign comp_sum = {1'b0, I_STRENGTH} + {1'b0, off_adj};
    // Clamped code; the mean adds clamped codes, so its sum never wraps
    assign comp_val = comp_sum < 9'h064 ? 8'h00
        : (comp_sum - 9'h064 > 9'h0FF ? 8'hFF : 8'(comp_sum - 9'h064));
    assign avg_sum = avg_acc_q + {2'b00, comp_val};
    // Strength per bit or four-bit mean; samples follow the channel filter
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cur_q <= 8'h00;
            avg_n_q <= 2'h0;
            avg_acc_q <= 10'h000;
        end else if (I_BIT_STB) begin
            if (!config_q[RXSQ_CFG_AVG_BIT]) begin
                cur_q <= comp_val;
            end else begin
                avg_n_q <= avg_n_q + 2'h1;
                if (avg_n_q == 2'h3) begin
                    cur_q <= avg_sum[9:2];
                    avg_acc_q <= 10'h000;
                end else begin
                    avg_acc_q <= avg_sum;
                end
            end
        end
    end

    // Latch point: count floor of four, or seven when averaging
    assign latch_min = config_q[RXSQ_CFG_AVG_BIT] ? RXSQ_CNT_AVG_MIN
        : RXSQ_CNT_MIN;
    always_comb begin
        latch_evt = 1'b0;
        unique case (config_q[1:0])
            RXSQ_SRC_PREAMBLE: latch_evt = I_PREAMBLE_DET;
            RXSQ_SRC_SYNC: latch_evt = I_SYNC_DET;
            default: latch_evt = I_BIT_STB;
        endcase
        if (bits_q < latch_min
            || bits_q < config_q[RXSQ_CFG_CNT_LSB +: 8]) begin
            latch_evt = latch_evt && (config_q[1:0] != RXSQ_SRC_COUNT)
                && !config_q[RXSQ_CFG_AVG_BIT];
        end
    end

    // Captured once per packet, cleared on receive entry
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            latched_q <= 8'h00;
            latch_done_q <= 1'b0;
        end else if (rx_start) begin
            latched_q <= 8'h00;
            latch_done_q <= 1'b0;
        end else if (I_RX_ACTIVE && latch_evt && !latch_done_q) begin
            latched_q <= cur_q;
            latch_done_q <= 1'b1;
        end
    end

    // Jump detection between successive updates inside a packet
    assign jump_diff = cur_q > prev_q ? cur_q - prev_q : prev_q - cur_q;
    assign jump_hit = jump_q[RXSQ_JMP_EN_BIT] && I_PACKET_BUSY && prev_ok_q
        && jump_diff > jump_q[RXSQ_JMP_LVL_LSB +: 8];
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            prev_q <= 8'h00;
            prev_ok_q <= 1'b0;
            O_JUMP_EVT <= 1'b0;
            O_RX_RESTART <= 1'b0;
        end else begin
            prev_q <= cur_q;
            prev_ok_q <= I_PACKET_BUSY && !jump_hit;
            O_JUMP_EVT <= jump_hit;
            O_RX_RESTART <= jump_hit && jump_q[RXSQ_JMP_RST_BIT];
        end
    end

    // Sticky status bits; a new event wins over a software clear
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            jump_st_q <= 1'b0;
            thl_q <= 1'b0;
        end else begin
            if (jump_hit) begin
                jump_st_q <= 1'b1;
            end else if (wr_en && I_PADDR[7:0] == RXSQ_CTRL_OFF
                && I_PWDATA[RXSQ_CTL_CLR_BIT]) begin
                jump_st_q <= 1'b0;
            end
            if (cur_q > thresh_q) begin
                thl_q <= 1'b1;
            end else if (rx_start || (wr_en && I_PADDR[7:0] == RXSQ_CTRL_OFF
                && I_PWDATA[RXSQ_CTL_CLR_BIT])) begin
                thl_q <= 1'b0;
            end
        end
    end
    assign O_THRESH_LEVEL = cur_q > thresh_q;
    assign O_THRESH_LATCHED = thl_q;

    // Status query snapshots both values; ready flag after the delay
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            q_cur_q <= 8'h00;
            q_lat_q <= 8'h00;
            cts_cnt_q <= 13'h0000;
            cts_q <= 1'b1;
        end else if (wr_en && I_PADDR[7:0] == RXSQ_QUERY_OFF) begin
            q_cur_q <= cur_q;
            q_lat_q <= latched_q;
            cts_cnt_q <= 13'(RXSQ_CTS_CYC - 1);
            cts_q <= 1'b0;
        end else if (!cts_q) begin
            if (cts_cnt_q == 13'h0000) begin
                cts_q <= 1'b1;
            end else begin
                cts_cnt_q <= cts_cnt_q - 13'h0001;
            end
        end
    end

    // Image calibration sequencer; longer first run
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cal_q <= RXSQ_CAL_IDLE;
            cal_cnt_q <= 28'h000_0000;
            cal_done_q <= 1'b0;
            first_cal_q <= 1'b1;
        end else begin
            unique case (cal_q)
                RXSQ_CAL_IDLE: begin
                    if (wr_en && I_PADDR[7:0] == RXSQ_CTRL_OFF
                        && I_PWDATA[RXSQ_CTL_CAL_BIT]) begin
                        cal_q <= RXSQ_CAL_RUN;
                        cal_cnt_q <= first_cal_q ? 28'(CAL_FIRST_CYC - 1)
                            : 28'(CAL_RE_CYC - 1);
                    end
                end
                RXSQ_CAL_RUN: begin
                    if (cal_cnt_q == 28'h000_0000) begin
                        cal_q <= RXSQ_CAL_IDLE;
                        cal_done_q <= 1'b1;
                        first_cal_q <= 1'b0;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 28'h000_0001;
                    end
                end
            endcase
        end
    end
    assign O_CAL_RUN = (cal_q == RXSQ_CAL_RUN);

    // Read mux; the fast word answers at once with no ready wait
    always_comb begin
        O_PRDATA = 32'h0000_0000;
        if (rd_en && mapped) begin
            unique case (I_PADDR[7:0])
                RXSQ_CONFIG_OFF: O_PRDATA = config_q;
                RXSQ_JUMP_OFF: O_PRDATA = jump_q;
                RXSQ_OFFSET_OFF: O_PRDATA = {25'h000_0000, offset_q};
                RXSQ_THRESH_OFF: O_PRDATA = {24'h00_0000, thresh_q};
                RXSQ_FAST_SEL_OFF: O_PRDATA = {30'h0000_0000, fast_sel_q};
                RXSQ_STATUS_OFF: O_PRDATA = {26'h000_0000, cal_done_q,
                    cts_q, O_THRESH_LEVEL, thl_q, jump_st_q, O_CAL_RUN};
                RXSQ_FAST_OFF: O_PRDATA = {24'h00_0000,
                    latched_q} << {fast_sel_q, 3'b000};
                RXSQ_QUERY_OFF: O_PRDATA = cts_q
                    ? {16'h0000, q_lat_q, q_cur_q} : 32'h0000_0000;
                RXSQ_MODEM_OFF: O_PRDATA = 32'h0000_0000;
                default: O_PRDATA = 32'h0000_0000;
            endcase
        end
    end

    // Latched value is zero in the cycle after receive entry
    clear_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        rx_start |=> latched_q == 8'h00) else $error("latch not cleared");
    jump_gated_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        O_JUMP_EVT |-> $past(jump_q[RXSQ_JMP_EN_BIT]))
        else $error("jump while disabled");
    restart_cause_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        O_RX_RESTART |-> O_JUMP_EVT) else $error("restart without jump");
    cts_delay_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        $fell(cts_q) |-> !cts_q [*8]) else $error("ready too soon");
    thresh_sticky_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        O_THRESH_LEVEL |=> thl_q) else $error("threshold not latched");
    latch_once_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        latch_done_q && !rx_start |=> $stable(latched_q))
        else $error("second latch");
    avg_floor_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        $rose(latch_done_q) && config_q[RXSQ_CFG_AVG_BIT]
        && config_q[1:0] == RXSQ_SRC_COUNT |-> $past(bits_q) >= 8'h07)
        else $error("latched before seven bits");
    cal_busy_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
        $rose(O_CAL_RUN) |-> O_CAL_RUN [*8]) else $error("cal too short");
endmodule : rxsq_monitor

// ==== rxsq_pkg.sv ====
// Constants for the receive signal-quality monitor.
// Assumes a 100 MHz clock and an APB master that keeps the standard protocol.
package rxsq_pkg;
    // Register byte offsets
    localparam logic [7:0] RXSQ_CONFIG_OFF = 8'h00;
    localparam logic [7:0] RXSQ_JUMP_OFF = 8'h04;
    localparam logic [7:0] RXSQ_OFFSET_OFF = 8'h08;
    localparam logic [7:0] RXSQ_THRESH_OFF = 8'h0C;
    localparam logic [7:0] RXSQ_FAST_SEL_OFF = 8'h10;
    localparam logic [7:0] RXSQ_CTRL_OFF = 8'h14;
    localparam logic [7:0] RXSQ_STATUS_OFF = 8'h18;
    localparam logic [7:0] RXSQ_FAST_OFF = 8'h1C;
    localparam logic [7:0] RXSQ_QUERY_OFF = 8'h20;
    localparam logic [7:0] RXSQ_MODEM_OFF = 8'h24;
    // Field positions of the strength config
    localparam int RXSQ_CFG_SRC_LSB = 0;
    localparam int RXSQ_CFG_AVG_BIT = 2;
    localparam int RXSQ_CFG_CNT_LSB = 8;
    // Field positions of the jump config
    localparam int RXSQ_JMP_EN_BIT = 0;
    localparam int RXSQ_JMP_RST_BIT = 1;
    localparam int RXSQ_JMP_LVL_LSB = 8;
    // Control and status bits
    localparam int RXSQ_CTL_CAL_BIT = 0;
    localparam int RXSQ_CTL_CLR_BIT = 1;
    localparam int RXSQ_ST_BUSY_BIT = 0;
    localparam int RXSQ_ST_JUMP_BIT = 1;
    localparam int RXSQ_ST_THL_BIT = 2;
    localparam int RXSQ_ST_THN_BIT = 3;
    localparam int RXSQ_ST_CTS_BIT = 4;
    localparam int RXSQ_ST_CALD_BIT = 5;
    // Latch sources
    localparam logic [1:0] RXSQ_SRC_PREAMBLE = 2'h0;
    localparam logic [1:0] RXSQ_SRC_SYNC = 2'h1;
    localparam logic [1:0] RXSQ_SRC_COUNT = 2'h2;
    // Reset values and latch count floors
    localparam logic [6:0] RXSQ_OFFSET_RST = 7'h32;
    localparam logic [7:0] RXSQ_CNT_MIN = 8'h04;
    localparam logic [7:0] RXSQ_CNT_AVG_MIN = 8'h07;
    localparam logic [31:0] RXSQ_CONFIG_RST = 32'h0000_0402;
    localparam logic [31:0] RXSQ_JUMP_RST = 32'h0000_0C00;
    localparam logic [7:0] RXSQ_THRESH_RST = 8'hFF;
    // Timing
    localparam int RXSQ_CLK_MHZ = 100;
    localparam int RXSQ_AGC_US = 2;
    localparam int RXSQ_AGC_CYC = RXSQ_AGC_US * RXSQ_CLK_MHZ;
    localparam int RXSQ_CTS_US = 33;
    localparam int RXSQ_CTS_CYC = RXSQ_CTS_US * RXSQ_CLK_MHZ;
    localparam int RXSQ_CAL_FIRST_MS = 250;
    localparam int RXSQ_CAL_FIRST_CYC = RXSQ_CAL_FIRST_MS * RXSQ_CLK_MHZ * 1000;
    localparam int RXSQ_CAL_RE_MS = 100;
    localparam int RXSQ_CAL_RE_CYC = RXSQ_CAL_RE_MS * RXSQ_CLK_MHZ * 1000;
    // Calibration states
    typedef enum logic [1:0] {
        RXSQ_CAL_IDLE = 2'b01,
        RXSQ_CAL_RUN = 2'b10
    } rxsq_cal_t;
endpackage : rxsq_pkg
